/* rtl/pwm_pkg.sv */
// Contract
// - Timer clears on increment after period match
// - Output goes active each period unless duty zero
// - Duty low byte copied to buffer at boundary
// - Period is (period+1)*4*prescale oscillator cycles
// - Postscaler never changes the PWM period
// - Duty is low byte plus control bits 5:4
// - Active time is duty*prescale oscillator cycles
// - Duty writes anytime; buffer read-only in PWM
// - Output cleared when buffer matches extended timer
// - Duty beyond period keeps output active
// - Standard module has no shutdown path
// - Bits 7:6 steer outputs; non-PWM uses A only
// - Config 00 drives A; 10 drives A/B complementary
// - Config 01 modulates D; 11 modulates B
// - Mode 0000 resets module; 0001/0011 do nothing
// - Modes 0100-0111 capture on chosen edges
// - Compare 0010 toggles; 1000 sets; 1001 clears
// - 1010 flags only; 1011 fires special event
// - Modes 11xx are PWM; bits 1:0 set polarity (enhanced channel only; the standard channel ignores them)
// - Outputs appear only when direction bits allow
// - Unimplemented bits ignore writes, read zero
// - Clearing control forces output latch low
package pwm_pkg;
	localparam int DW = 8;
	localparam int AW = 4;
	localparam int NCH = 2;
	// Register addresses; channel 0 standard, channel 1 enhanced
	localparam logic [AW-1:0] A_TIMER2_COUNT = 4'h0;
	localparam logic [AW-1:0] A_PERIOD = 4'h1;
	localparam logic [AW-1:0] A_T2CFG = 4'h2;
	localparam logic [AW-1:0] A_STATUS = 4'h3;
	localparam logic [AW-1:0] A_DIR = 4'h4;
	localparam logic [AW-1:0] A_LO [NCH] = '{4'h5, 4'h8};
	localparam logic [AW-1:0] A_HI [NCH] = '{4'h6, 4'h9};
	localparam logic [AW-1:0] A_CTRL [NCH] = '{4'h7, 4'hA};
	localparam logic [DW-1:0] CTRL_MASK [NCH] = '{8'h3F, 8'hFF};
	localparam logic [DW-1:0] T2CFG_MASK = 8'h7F;
	localparam logic [DW-1:0] DIR_MASK = 8'h1F;
	localparam logic [DW-1:0] STATUS_MASK = 8'h07;
	// Timer2 configuration fields
	localparam int T2_ON = 2;
	localparam int T2_PS = 0;
	localparam int T2_POST = 3;
	localparam logic [1:0] PS_1 = 2'h0;
	localparam logic [1:0] PS_4 = 2'h1;
	localparam logic [3:0] PRE_LAST_4 = 4'h3;
	localparam logic [3:0] PRE_LAST_16 = 4'hF;
	localparam logic [1:0] Q_LAST = 2'h3;
	// Control register fields
	localparam int CFG_LSB = 6;
	localparam int DC_LSB = 4;
	localparam int POL_AC = 1;
	localparam int POL_BD = 0;
	localparam logic [1:0] CFG_SINGLE = 2'h0;
	localparam logic [1:0] CFG_FWD = 2'h1;
	localparam logic [1:0] CFG_HALF = 2'h2;
	localparam logic [1:0] CFG_REV = 2'h3;
	// Mode codes
	localparam logic [3:0] M_OFF = 4'h0;
	localparam logic [3:0] M_TOGGLE = 4'h2;
	localparam logic [3:0] M_CAP_FALL = 4'h4;
	localparam logic [3:0] M_CAP_RISE = 4'h5;
	localparam logic [3:0] M_CAP_4 = 4'h6;
	localparam logic [3:0] M_CAP_16 = 4'h7;
	localparam logic [3:0] M_CMP_SET = 4'h8;
	localparam logic [3:0] M_CMP_CLR = 4'h9;
	localparam logic [3:0] M_CMP_SW = 4'hA;
	localparam logic [3:0] M_CMP_EVT = 4'hB;
	localparam logic [3:0] CAP_LAST_4 = 4'h3;
	localparam logic [3:0] CAP_LAST_16 = 4'hF;
	// Status and direction bit positions
	localparam int ST_T2 = 0;
	localparam int ST_CH = 1;
	localparam int DIR_STD = 0;
	localparam int DIR_BR = 1;

	typedef enum logic [1:0] {
		MODE_OFF = 2'b00,
		MODE_CAPTURE = 2'b01,
		MODE_COMPARE = 2'b11,
		MODE_PWM = 2'b10
	} mode_t;

	typedef struct packed {
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic [3:0] level;
		logic [3:0] drive;
	} bridge_pins_t;

	// Reserved codes fall into OFF-like idle without resetting
	function automatic mode_t decode_mode(input logic [3:0] m);
		mode_t r;
		r = MODE_OFF;
		if (m[3:2] == 2'h3)
			r = MODE_PWM;
		else if (m == M_TOGGLE || m[3:2] == 2'h2)
			r = MODE_COMPARE;
		else if (m[3:2] == 2'h1)
			r = MODE_CAPTURE;
		return r;
	endfunction
endpackage

/* rtl/pwm_ccp.sv */
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module pwm_ccp import pwm_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire reg_req_t req,
	output logic [DW-1:0] rdata,
	// Capture pins and shared 16-bit timer
	input wire logic [NCH-1:0] capture_pin,
	input wire logic [2*DW-1:0] timer13_count,
	// Special event outputs
	output logic timer13_reset,
	output logic adc_start,
	// Standard output pin
	output logic std_level,
	output logic std_drive,
	// Enhanced bridge outputs A..D in bits 0..3
	output bridge_pins_t bridge
);
	logic [DW-1:0] timer2_count, period, t2cfg, status, dir;
	logic [1:0] q;
	logic [3:0] pre, post;
	logic [NCH-1:0] cap_s1, cap_s2, cap_d;
	logic [DW-1:0] lo [NCH];
	logic [DW-1:0] hi [NCH];
	logic [DW-1:0] ctrl [NCH];
	logic [1:0] lat2 [NCH];
	logic [NCH-1:0] pwm_lvl, pwm_out, cmp_pin, evt, special;
	logic [DW-1:0] next_rdata;

	// Timer2 timing decode
	wire inst_tick = (q == Q_LAST);
	wire [1:0] ps = t2cfg[T2_PS+:2];
	wire [3:0] pre_last = (ps == PS_1) ? 4'h0 :
		(ps == PS_4) ? PRE_LAST_4 : PRE_LAST_16;
	wire tmr_inc = t2cfg[T2_ON] && inst_tick && (pre == pre_last);
	wire boundary = tmr_inc && (timer2_count == period);
	wire post_hit = boundary && (post == t2cfg[T2_POST+:4]);
	// Sub-count extends the timer in prescale units
	wire [1:0] sub = (ps == PS_1) ? q :
		(ps == PS_4) ? pre[1:0] : pre[3:2];
	wire wr_timer2_count = req.wr && req.addr == A_TIMER2_COUNT;
	wire wr_status = req.wr && req.addr == A_STATUS;

	// Instruction clock: four oscillator cycles per tick
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			q <= 2'h0;
		else
			q <= q + 2'h1;
	end

	// Prescaler and timer; a timer write also clears the prescaler
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pre <= 4'h0;
			timer2_count <= 8'h00;
		end else if (wr_timer2_count) begin
			pre <= 4'h0;
			timer2_count <= req.wdata;
		end else if (t2cfg[T2_ON] && inst_tick) begin
			pre <= (pre == pre_last) ? 4'h0 : pre + 4'h1;
			if (boundary)
				timer2_count <= 8'h00;
			else if (tmr_inc)
				timer2_count <= timer2_count + 8'h01;
		end
	end

	// Postscaler only paces the timer flag, never the period
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			post <= 4'h0;
		else if (boundary)
			post <= post_hit ? 4'h0 : post + 4'h1;
	end

	// Plain configuration registers, unimplemented bits dropped
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			period <= 8'hFF;
			t2cfg <= 8'h00;
			dir <= 8'h00;
		end else if (req.wr) begin
			if (req.addr == A_PERIOD)
				period <= req.wdata;
			if (req.addr == A_T2CFG)
				t2cfg <= req.wdata & T2CFG_MASK;
			if (req.addr == A_DIR)
				dir <= req.wdata & DIR_MASK;
		end
	end

	// Sticky event flags; write one clears, a new event wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			status <= 8'h00;
		else
			status <= ((status & ~(wr_status ? req.wdata : 8'h00))
				| {5'h00, evt, post_hit}) & STATUS_MASK;
	end

	// Capture pins come from outside: two-stage synchroniser
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cap_s1 <= '0;
			cap_s2 <= '0;
			cap_d <= '0;
		end else begin
			cap_s1 <= capture_pin;
			cap_s2 <= cap_s1;
			cap_d <= cap_s2;
		end
	end

	// One capture/compare/PWM channel per control register
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		wire [3:0] mbits = ctrl[i][3:0];
		wire mode_t md = decode_mode(mbits);
		wire [3:0] wmode = req.wdata[3:0];
		wire wr_lo = req.wr && req.addr == A_LO[i];
		wire wr_ctrl = req.wr && req.addr == A_CTRL[i];
		// Buffer byte is read-only while the channel runs PWM
		wire wr_hi = req.wr && req.addr == A_HI[i]
			&& md != MODE_PWM;
		wire rise = cap_s2[i] && !cap_d[i];
		wire fall = !cap_s2[i] && cap_d[i];
		wire [9:0] duty_next = {lo[i], ctrl[i][DC_LSB+:2]};
		// Match only once the extended timer reaches the duty;
		// a duty past the period never matches
		wire pwm_clear = {hi[i], lat2[i]} == {timer2_count, sub};
		wire cmp_hit = {hi[i], lo[i]} == timer13_count;
		logic cmp_d;
		logic [3:0] cap_cnt;
		wire cmp_rise = md == MODE_COMPARE && cmp_hit && !cmp_d;
		wire cap_fire = (mbits == M_CAP_FALL && fall)
			|| (mbits == M_CAP_RISE && rise)
			|| (mbits == M_CAP_4 && rise && cap_cnt == CAP_LAST_4)
			|| (mbits == M_CAP_16 && rise
			&& cap_cnt == CAP_LAST_16);

		assign evt[i] = cap_fire || cmp_rise;
		assign special[i] = cmp_rise && mbits == M_CMP_EVT;
		// Match drops the level in its own cycle; the registered latch
		// alone would stretch the active time by one clock
		assign pwm_out[i] = pwm_lvl[i] && !pwm_clear;

		// Channel registers and output latch
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				lo[i] <= 8'h00;
				hi[i] <= 8'h00;
				ctrl[i] <= 8'h00;
				lat2[i] <= 2'h0;
				pwm_lvl[i] <= 1'b0;
				cmp_pin[i] <= 1'b0;
				cmp_d <= 1'b0;
				cap_cnt <= 4'h0;
			end else begin
				cmp_d <= cmp_hit;
				if (wr_lo)
					lo[i] <= req.wdata;
				else if (cap_fire)
					lo[i] <= timer13_count[DW-1:0];
				if (wr_hi)
					hi[i] <= req.wdata;
				else if (cap_fire)
					hi[i] <= timer13_count[2*DW-1:DW];
				else if (md == MODE_PWM && boundary)
					hi[i] <= lo[i];
				if (mbits == M_OFF) begin
					// Off resets the channel, latch forced low
					lat2[i] <= 2'h0;
					pwm_lvl[i] <= 1'b0;
					cmp_pin[i] <= 1'b0;
					cap_cnt <= 4'h0;
				end
				if (md == MODE_PWM) begin
					if (boundary) begin
						lat2[i] <= duty_next[1:0];
						pwm_lvl[i] <= duty_next != 10'h000;
					end else if (pwm_clear) begin
						pwm_lvl[i] <= 1'b0;
					end
				end
				if (md == MODE_CAPTURE && rise)
					cap_cnt <= (cap_fire) ? 4'h0 : cap_cnt + 4'h1;
				if (cmp_rise) begin
					if (mbits == M_TOGGLE)
						cmp_pin[i] <= !cmp_pin[i];
					else if (mbits == M_CMP_SET)
						cmp_pin[i] <= 1'b1;
					else if (mbits == M_CMP_CLR)
						cmp_pin[i] <= 1'b0;
				end
				if (wr_ctrl) begin
					ctrl[i] <= req.wdata & CTRL_MASK[i];
					cap_cnt <= 4'h0;
					// Entering set or clear compare mode sets the start level
					if (wmode == M_CMP_SET)
						cmp_pin[i] <= 1'b0;
					else if (wmode == M_CMP_CLR)
						cmp_pin[i] <= 1'b1;
				end
			end
		end
	end

	// Standard channel: no polarity, no steering, no shutdown
	wire mode_t md0 = decode_mode(ctrl[0][3:0]);
	wire std_used = md0 == MODE_PWM
		|| (md0 == MODE_COMPARE && ctrl[0][3:0] != M_CMP_SW);
	wire next_std_level = (md0 == MODE_PWM) ? pwm_out[0]
		: cmp_pin[0];

	// Enhanced steering of the four bridge outputs
	wire mode_t md1 = decode_mode(ctrl[1][3:0]);
	wire [1:0] cfg = ctrl[1][CFG_LSB+:2];
	wire p1 = pwm_out[1];
	wire ac_low = ctrl[1][POL_AC];
	wire bd_low = ctrl[1][POL_BD];
	logic [3:0] act, used;
	always_comb begin
		act = 4'h0;
		used = 4'h0;
		if (md1 == MODE_PWM) begin
			case (cfg)
			CFG_SINGLE: begin
				act = {3'h0, p1};
				used = 4'h1;
			end
			CFG_FWD: begin
				act = {p1, 2'h0, 1'b1};
				used = 4'hF;
			end
			CFG_HALF: begin
				act = {2'h0, !p1, p1};
				used = 4'h3;
			end
			CFG_REV: begin
				act = {1'b0, 1'b1, p1, 1'b0};
				used = 4'hF;
			end
			default: begin
				act = 4'h0;
				used = 4'h0;
			end
			endcase
		end else if (md1 == MODE_COMPARE) begin
			act = {3'h0, cmp_pin[1]};
			used = {3'h0, ctrl[1][3:0] != M_CMP_SW};
		end
	end
	// Polarity only applies in PWM: A,C on bit 1, B,D on bit 0
	wire [3:0] inv = (md1 == MODE_PWM) ?
		{bd_low, ac_low, bd_low, ac_low} : 4'h0;
	wire [3:0] br_en = used & dir[DIR_BR+:4];

	// Read selection
	always_comb begin
		next_rdata = 8'h00;
		case (req.addr)
		A_TIMER2_COUNT: next_rdata = timer2_count;
		A_PERIOD: next_rdata = period;
		A_T2CFG: next_rdata = t2cfg;
		A_STATUS: next_rdata = status;
		A_DIR: next_rdata = dir;
		A_LO[0]: next_rdata = lo[0];
		A_HI[0]: next_rdata = hi[0];
		A_CTRL[0]: next_rdata = ctrl[0];
		A_LO[1]: next_rdata = lo[1];
		A_HI[1]: next_rdata = hi[1];
		A_CTRL[1]: next_rdata = ctrl[1];
		default: next_rdata = 8'h00;
		endcase
	end

	// Registered pins and read data; outputs lag the latch by one clock
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= 8'h00;
			std_level <= 1'b0;
			std_drive <= 1'b0;
			bridge <= '0;
			timer13_reset <= 1'b0;
			adc_start <= 1'b0;
		end else begin
			rdata <= req.rd ? next_rdata : 8'h00;
			std_level <= next_std_level;
			std_drive <= std_used && dir[DIR_STD];
			bridge.level <= act ^ inv;
			bridge.drive <= br_en;
			timer13_reset <= |special;
			adc_start <= |special;
		end
	end
endmodule
`default_nettype wire

/* verification/pwm_ccp_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module pwm_ccp_chk import pwm_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Watched ports
	input wire reg_req_t req,
	input wire logic [DW-1:0] rdata,
	input wire logic timer13_reset,
	input wire logic adc_start,
	input wire logic std_level,
	input wire bridge_pins_t bridge
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Register port read-back
	a_unmapped_zero: assert property ( // Unmapped
		req.rd && req.addr > A_CTRL[1] |=> rdata == 8'h00)
		else $error("unmapped read gave data");
	a_std_top_zero: assert property ( // Top bits
		req.rd && req.addr == A_CTRL[0] |=> rdata[7:6] == 2'h0)
		else $error("standard control top bits read set");
	a_period_back: assert property ( // Period
		req.wr && req.addr == A_PERIOD ##1 req.rd && req.addr == A_PERIOD
		|=> rdata == $past(req.wdata, 2))
		else $error("period read-back wrong");
	a_ctrl_back: assert property ( // Mode codes
		req.wr && req.addr == A_CTRL[1] ##1 req.rd && req.addr == A_CTRL[1]
		|=> rdata == $past(req.wdata, 2))
		else $error("enhanced control read-back wrong");
	// Special event pulses
	a_event_pair: assert property ( // Paired
		timer13_reset |-> adc_start)
		else $error("event pulses not paired");
	a_event_pulse: assert property ( // One cycle
		timer13_reset |=> !timer13_reset)
		else $error("event pulse too long");
	// Output steering; pins lag the control write by two edges
	a_off_low: assert property ( // Off
		req.wr && req.addr == A_CTRL[0] && req.wdata[3:0] == M_OFF
		|-> ##[1:3] !std_level)
		else $error("standard output not cleared by off");
	a_dir_gate: assert property ( // Direction
		req.wr && req.addr == A_DIR && req.wdata[4:1] == 4'h0
		|-> ##[2:3] bridge.drive == 4'h0)
		else $error("bridge driven without direction");
	a_port_pins: assert property ( // Port pins
		req.wr && req.addr == A_CTRL[1]
		&& (req.wdata[3:2] != 2'h3 || req.wdata[7:6] == CFG_SINGLE)
		|-> ##[2:3] bridge.drive[3:1] == 3'h0)
		else $error("unused bridge outputs driven");
	// Main scenarios
	c_event: cover property ($rose(timer13_reset));
	c_pwm_edge: cover property ($fell(std_level));
	c_back_to_back: cover property (req.wr ##1 req.rd);
endmodule
`default_nettype wire

/* verification/pwm_load.sv */
`timescale 1ns/1ps
`default_nettype none
module pwm_load import pwm_pkg::*; (
	// Pin levels and enables from the block
	input wire logic std_level,
	input wire logic std_drive,
	input wire bridge_pins_t bridge,
	// Level each load sees: std pin in bit 0, A..D above
	output logic [4:0] seen
);
	// Loads sit on pull-downs, so an undriven pin reads low
	assign seen = {bridge.drive & bridge.level, std_drive & std_level};
endmodule
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench import pwm_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	reg_req_t req = '0;
	logic [NCH-1:0] cap = '0;
	logic [15:0] t13 = '0;
	logic [DW-1:0] rdata;
	logic t13_rst, adc, std_level, std_drive;
	bridge_pins_t bridge;
	logic [4:0] seen;
	int errors = 0;
	int n_tests = 0;
	int cycles = 0;
	logic [15:0] cnt [5];
	logic [7:0] q;
	logic [15:0] v;
	// Kind of A..D per config: 0 off, 1 on, 2 pwm, 3 inverse, 4 port
	int kinds [4][4] = '{'{2, 4, 4, 4}, '{1, 0, 0, 2}, '{2, 3, 4, 4},
		'{0, 2, 1, 0}};

	always #2 clk = ~clk;

	pwm_ccp dut_u (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
		.capture_pin(cap), .timer13_count(t13), .timer13_reset(t13_rst),
		.adc_start(adc), .std_level(std_level), .std_drive(std_drive),
		.bridge(bridge));
	pwm_load load_u (.std_level(std_level), .std_drive(std_drive),
		.bridge(bridge), .seen(seen));

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req <= '0;
	endtask

	// Optional write, then a read of the same place with no gap
	task automatic xfer(input bit w, input logic [3:0] a,
			input logic [7:0] wd, output logic [7:0] d);
		@(posedge clk);
		if (w) begin
			req <= '{addr: a, wdata: wd, wr: 1'b1, rd: 1'b0};
			@(posedge clk);
		end
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req <= '0;
		#1 d = rdata;
	endtask

	// High cycles per load; whole periods make it phase independent
	task automatic measure(input int w);
		cnt = '{default: '0};
		repeat (w) begin
			@(negedge clk);
			for (int i = 0; i < 5; i++)
				cnt[i] += 16'(seen[i]);
		end
	endtask

	function automatic logic [15:0] exp_cnt(int kind, int pol, int w, int h);
		int raw;
		raw = kind == 1 ? w : kind == 2 ? h : kind == 3 ? w - h : 0;
		if (kind != 4 && pol != 0)
			raw = w - raw;
		return 16'(raw);
	endfunction

	// One PWM setup in the recommended order, then both channels measured
	task automatic run_pwm(input int i);
		int p, ps, psf, duty, w, h;
		p = $urandom % 12;
		ps = $urandom % 4;
		psf = ps == 0 ? 1 : ps == 1 ? 4 : 16;
		w = (p + 1) * 4;
		duty = i == 0 ? 0 : i == 1 ? 1023 : i == 2 ? w : $urandom % (w + 4);
		h = duty < w ? duty : w;
		wr(A_T2CFG, 8'h00);
		wr(A_TIMER2_COUNT, 8'h00);
		wr(A_PERIOD, 8'(p));
		wr(A_LO[0], 8'(duty >> 2));
		wr(A_LO[1], 8'(duty >> 2));
		wr(A_DIR, DIR_MASK);
		wr(A_T2CFG, {1'b0, 4'($urandom), 1'b1, 2'(ps)});
		wr(A_CTRL[0], {2'h0, 2'(duty), 2'h3, 2'(i >> 1)});
		wr(A_CTRL[1], {2'(i), 2'(duty), 2'h3, 2'(i >> 1)});
		repeat (2 * w * psf + 10) @(posedge clk);
		measure(2 * w * psf);
		chk(cnt[0], 16'(2 * h * psf));
		for (int k = 0; k < 4; k++)
			chk(cnt[k + 1], exp_cnt(kinds[i % 4][k], (i >> (2 - k % 2)) & 1,
				2 * w * psf, 2 * h * psf));
		xfer(1, A_HI[0], ~8'(duty >> 2), q);
		chk(q, 16'(duty >> 2));
		xfer(0, A_TIMER2_COUNT, 8'h00, q);
		chk(16'(q <= p), 16'h1);
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 100000) begin
			errors++;
			give_verdict();
		end
	end

	initial begin
		void'($urandom(32'h04e84132));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (int a = 0; a < 16; a++) begin
			xfer(0, 4'(a), 8'h00, q);
			chk(q, a == 1 ? 16'hFF : 16'h0);
		end
		xfer(1, A_CTRL[0], 8'hF0, q);
		chk(q, 16'h30);
		xfer(1, A_T2CFG, 8'h80, q);
		chk(q, 16'h0);
		xfer(1, A_PERIOD, 8'h5A, q);
		chk(q, 16'h5A);
		for (int m = 0; m < 16; m++) begin
			xfer(1, A_CTRL[1], {2'(m), 2'h0, 4'(m)}, q);
			chk(q, {8'h0, 2'(m), 2'h0, 4'(m)});
		end
		wr(A_CTRL[1], 8'h00);
		// Compare: set on match, then special event
		wr(A_DIR, 8'h01);
		wr(A_LO[0], 8'h34);
		wr(A_HI[0], 8'h12);
		wr(A_CTRL[0], {4'h0, M_CMP_SET});
		measure(4);
		chk(seen[0], 16'h0);
		@(posedge clk);
		t13 <= 16'h1234;
		measure(6);
		chk(seen[0], 16'h1);
		xfer(0, A_STATUS, 8'h00, q);
		chk(q[ST_CH], 16'h1);
		@(posedge clk);
		t13 <= 16'h0000;
		wr(A_CTRL[0], {4'h0, M_CMP_EVT});
		t13 <= 16'h1234;
		v = 0;
		repeat (8) begin
			@(negedge clk);
			v += 16'(t13_rst);
		end
		chk(v, 16'h1);
		// Toggle on every fresh match of the enhanced channel
		wr(A_DIR, 8'h03);
		wr(A_CTRL[1], {4'h0, M_TOGGLE});
		for (int t = 1; t >= 0; t--) begin
			@(posedge clk);
			t13 <= 16'h0000;
			repeat (4) @(posedge clk);
			t13 <= 16'h0001;
			@(negedge clk);
			chk(16'(seen[1]), 16'(t));
		end
		// Capture on a rising pin edge takes the running count
		@(posedge clk);
		v = 16'($urandom);
		t13 <= v;
		wr(A_CTRL[0], {4'h0, M_CAP_RISE});
		cap <= 2'b11;
		repeat (8) @(posedge clk);
		xfer(0, A_LO[0], 8'h00, q);
		chk(q, v[7:0]);
		xfer(0, A_HI[0], 8'h00, q);
		chk(q, v[15:8]);
		// Falling edge capture, then every 4th rise on the enhanced pin
		wr(A_CTRL[0], {4'h0, M_CAP_FALL});
		v = 16'($urandom);
		t13 <= v;
		cap <= 2'b00;
		repeat (8) @(posedge clk);
		xfer(0, A_LO[0], 8'h00, q);
		chk(q, v[7:0]);
		wr(A_CTRL[1], {4'h0, M_CAP_4});
		for (int e = 1; e <= 4; e++) begin
			@(posedge clk);
			t13 <= 16'(e);
			cap <= 2'b10;
			repeat (4) @(posedge clk);
			cap <= 2'b00;
			xfer(0, A_LO[1], 8'h00, q);
			chk(q, e == 4 ? 16'h4 : 16'h0);
		end
		for (int i = 0; i < 8; i++)
			run_pwm(i);
		// Off clears the standard output; no direction, no drive
		wr(A_CTRL[0], 8'h00);
		// Pins lag the register write by two clocks
		repeat (2) @(posedge clk);
		measure(100);
		chk(cnt[0], 16'h0);
		chk(16'(std_level), 16'h0);
		wr(A_DIR, 8'h00);
		repeat (2) @(posedge clk);
		measure(100);
		for (int k = 1; k < 5; k++)
			chk(cnt[k], 16'h0);
		give_verdict();
	end
endmodule

bind pwm_ccp pwm_ccp_chk chk_u (.clk(clk), .rst(rst), .req(req),
	.rdata(rdata), .timer13_reset(timer13_reset), .adc_start(adc_start),
	.std_level(std_level), .bridge(bridge));
`default_nettype wire
